// file: pkg/ni_framer_pkg.sv
// Shared constants and types for the node identification indicator framer
package ni_framer_pkg;
  localparam logic [7:0]  START_DELIM = 8'h7e;
  localparam logic [7:0]  FRAME_TYPE  = 8'h95;
  localparam logic [7:0]  OPT_KEEP    = 8'hce;
  localparam logic [15:0] NO_PARENT   = 16'hfffe;
  localparam logic [7:0]  CSUM_BASE   = 8'hff;
  localparam logic [7:0]  PAD_CHAR    = 8'h20;
  localparam logic [7:0]  NULL_CHAR   = 8'h00;
  localparam logic [7:0]  EVT_BUTTON  = 8'h01;
  localparam logic [7:0]  EVT_JOIN    = 8'h02;
  localparam logic [7:0]  EVT_POWER   = 8'h03;
  localparam int          HEAD_BYTES  = 3;
  localparam int          PRE_BYTES   = 22;
  localparam int          POST_BASE   = 8;
  localparam int          DTYPE_BYTES = 4;
  localparam int          RSSI_BYTES  = 1;
  localparam int          MIN_STR     = 2;
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_CMD     = 12'h004;
  localparam logic [11:0] REG_STATUS  = 12'h008;
  localparam int          CTRL_DTYPE  = 0;
  localparam int          CTRL_RSSI   = 1;
  localparam int          CTRL_JOIN   = 2;
  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  localparam logic [31:0] CMD_COMMISSION = 32'h1;
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_HEAD = 6'b000010,
    S_PRE  = 6'b000100,
    S_STR  = 6'b001000,
    S_POST = 6'b010000,
    S_CSUM = 6'b100000
  } state_t;
endpackage

// file: pkg/framer_link_if.sv
// Links the framer to its string buffer and checksum accumulator
interface framer_link_if;
  logic       wr;
  logic [7:0] wdata;
  logic       clr;
  logic [7:0] raddr;
  logic [7:0] rdata;
  logic [7:0] count;
  logic       sum_clr;
  logic       sum_en;
  logic [7:0] sum_data;
  logic [7:0] sum;
  modport main (output wr, wdata, clr, raddr, sum_clr, sum_en, sum_data,
                input rdata, count, sum);
  modport sbuf (input wr, wdata, clr, raddr, output rdata, count);
  modport csum (input sum_clr, sum_en, sum_data, output sum);
endinterface

// file: design/ident_string_buf.sv
// Holds the remote identifier characters awaiting framing
module ident_string_buf #(
  parameter int DEPTH = 32
) (
  input wire logic   i_clk_sys,
  input wire logic   i_rst_n,
  framer_link_if.sbuf lk
);
  logic [7:0] mem [DEPTH];
  logic [7:0] count;

  // Characters past the depth are dropped rather than wrapping
  always_ff @(posedge i_clk_sys) begin
    if (lk.wr && (count < 8'(DEPTH))) begin
      mem[count[$clog2(DEPTH)-1:0]] <= lk.wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= 8'h00;
    end else if (lk.clr) begin
      count <= 8'h00;
    end else if (lk.wr && (count < 8'(DEPTH))) begin
      count <= count + 8'h01;
    end
  end

  assign lk.count = count;
  assign lk.rdata = mem[lk.raddr[$clog2(DEPTH)-1:0]];
endmodule // ident_string_buf

// file: design/frame_checksum.sv
// Running eight-bit sum of the bytes covered by the checksum
module frame_checksum (
  input wire logic   i_clk_sys,
  input wire logic   i_rst_n,
  framer_link_if.csum lk
);
  logic [7:0] sum;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum <= 8'h00;
    end else if (lk.sum_clr) begin
      sum <= 8'h00;
    end else if (lk.sum_en) begin
      sum <= sum + lk.sum_data;
    end
  end

  assign lk.sum = sum;
endmodule // frame_checksum

// file: design/node_ident_indicator_framer.sv
// Node identification indicator frame builder with APB control
//
// Behaviour
// [RULE_01] Emit one indicator frame for every received identification broadcast.
// [RULE_02] Broadcast on button, command value 1, join or power-up with notify.
// [RULE_03] Each frame opens with start delimiter 7E at offset zero.
// [RULE_04] Sixteen-bit length at offset 1 counts bytes before the checksum.
// [RULE_05] Frame type byte at offset 3 is 95 hex.
// [RULE_06] Sender 64-bit address at offset 4, 16-bit address at 12.
// [RULE_07] Options byte: bit1 broadcast, bit2 all-PAN; bits 0,4,5 reserved.
// [RULE_08] Options bits 7:6 carry the mesh delivery method.
// [RULE_09] Remote 16-bit address at offset 15, 64-bit address at 17.
// [RULE_10] Identifier string at 25, null terminated, two bytes minimum.
// [RULE_11] Parent address follows string; FFFE when remote has no parent.
// [RULE_12] Role byte: coordinator 0, router 1, end device 2.
// [RULE_13] Source event byte: 1 button, 2 joined, 3 power cycle.
// [RULE_14] Two fixed words: application profile then manufacturer code.
// [RULE_15] Optional 32-bit device type word when its option bit is set.
// [RULE_16] Optional last-hop signal byte before checksum when enabled.
// [RULE_17] Checksum is FF minus low byte of sum from offset 3 on.
// [RULE_18] Fields go most significant byte first, one byte per transfer.
module node_ident_indicator_framer
  import ni_framer_pkg::*;
#(
  parameter int          STR_DEPTH  = 32,
  parameter logic [15:0] PROFILE_ID = 16'h0a0b, // Arbitrary value
  parameter logic [15:0] MAKER_ID   = 16'h0c0d  // Arbitrary value
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_id_valid,
  output logic             o_id_ready,
  input  wire logic [63:0] i_src64,
  input  wire logic [15:0] i_src16,
  input  wire logic [7:0]  i_options,
  input  wire logic [15:0] i_rem16,
  input  wire logic [63:0] i_rem64,
  input  wire logic [15:0] i_parent16,
  input  wire logic        i_has_parent,
  input  wire logic [7:0]  i_role,
  input  wire logic [7:0]  i_event,
  input  wire logic [31:0] i_dev_type,
  input  wire logic [7:0]  i_rssi,
  input  wire logic        i_str_wr,
  input  wire logic [7:0]  i_str_byte,
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_data,
  output logic             o_tx_last,
  input  wire logic        i_tx_ready,
  input  wire logic        i_button_press,
  input  wire logic        i_joined,
  input  wire logic        i_power_assoc,
  output logic             o_ident_send,
  output logic      [7:0]  o_ident_event
);
  localparam int PRE_W  = PRE_BYTES * 8;
  localparam int POST_W = (POST_BASE + DTYPE_BYTES + RSSI_BYTES) * 8;

  // The buffer index needs at least one address bit
  if (STR_DEPTH < 2 || STR_DEPTH > 200) begin : g_bad_depth
    $error("STR_DEPTH must lie between 2 and 200");
  end

  framer_link_if lk ();

  logic              rst_meta_n;
  logic              rst_sync_n;
  state_t            state;
  state_t            next_state;
  logic [7:0]        idx;
  logic [PRE_W-1:0]  pre_vec;
  logic [POST_W-1:0] post_vec;
  logic [7:0]        post_n;
  logic              has_parent_q;
  logic [2:0]        ctrl;
  logic [15:0]       frame_cnt;
  logic [15:0]       frame_len;
  logic [7:0]        str_n;
  logic [7:0]        cur_byte;
  logic              last_in_state;
  logic              load;
  logic              accept;
  logic              cmd_trig;
  logic              apb_acc;
  logic              apb_done;

  // Reset is released through two flops so every register leaves it together
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  ident_string_buf #(.DEPTH(STR_DEPTH)) u_str (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_sync_n),
    .lk        (lk.sbuf)
  );

  frame_checksum u_sum (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_sync_n),
    .lk        (lk.csum)
  );

  // An empty identifier is sent as one space plus null
  assign str_n = ((lk.count == 8'h00) ? 8'h01 : lk.count) + 8'h01; // [RULE_10]
  // Trailer size comes from post_n, latched at accept, so a control
  // write during a frame cannot make the length disagree with the body
  assign frame_len = 16'(PRE_BYTES) + {8'h00, str_n}
                   + {8'h00, post_n}; // [RULE_04]

  assign accept = i_id_valid && o_id_ready;
  assign load   = (state != S_IDLE) && (!o_tx_valid || i_tx_ready);

  // Byte source for the current position; vectors shift out MSB first
  always_comb begin
    cur_byte      = 8'h00;
    last_in_state = 1'b0;
    case (state)
      S_HEAD: begin
        cur_byte = (idx == 8'h00) ? START_DELIM : // [RULE_03]
                   (idx == 8'h01) ? frame_len[15:8] : frame_len[7:0]; // [RULE_04]
        last_in_state = (idx == 8'(HEAD_BYTES - 1));
      end
      S_PRE: begin
        cur_byte      = pre_vec[PRE_W-1 -: 8]; // [RULE_18]
        last_in_state = (idx == 8'(PRE_BYTES - 1));
      end
      S_STR: begin
        if (idx < lk.count) begin
          cur_byte = lk.rdata;
        end else if (lk.count == 8'h00 && idx == 8'h00) begin
          cur_byte = PAD_CHAR;
        end else begin
          cur_byte = NULL_CHAR; // [RULE_10]
        end
        last_in_state = (idx == str_n - 8'h01);
      end
      S_POST: begin
        cur_byte      = post_vec[POST_W-1 -: 8]; // [RULE_18]
        last_in_state = (idx == post_n - 8'h01);
      end
      S_CSUM: begin
        cur_byte      = CSUM_BASE - lk.sum; // [RULE_17]
        last_in_state = 1'b1;
      end
      default: begin
        cur_byte      = 8'h00;
        last_in_state = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: if (accept) next_state = S_HEAD; // [RULE_01]
      S_HEAD: if (load && last_in_state) next_state = S_PRE;
      S_PRE:  if (load && last_in_state) next_state = S_STR;
      S_STR:  if (load && last_in_state) next_state = S_POST;
      S_POST: if (load && last_in_state) next_state = S_CSUM;
      S_CSUM: if (load) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state      <= S_IDLE;
      idx        <= 8'h00;
      o_id_ready <= 1'b0;
    end else begin
      state      <= next_state;
      o_id_ready <= (next_state == S_IDLE);
      if (next_state != state) begin
        idx <= 8'h00;
      end else if (load) begin
        idx <= idx + 8'h01;
      end
    end
  end

  // Field images are latched at accept, so inputs may change afterwards
  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pre_vec      <= '0;
      post_vec     <= '0;
      post_n       <= 8'h00;
      has_parent_q <= 1'b0;
    end else if (accept) begin
      has_parent_q <= i_has_parent;
      pre_vec <= {FRAME_TYPE, // [RULE_05]
                  i_src64, i_src16, // [RULE_06]
                  i_options & OPT_KEEP, // [RULE_07] [RULE_08]
                  i_rem16, i_rem64}; // [RULE_09]
      post_n <= 8'(POST_BASE)
              + (ctrl[CTRL_DTYPE] ? 8'(DTYPE_BYTES) : 8'h00)
              + (ctrl[CTRL_RSSI] ? 8'(RSSI_BYTES) : 8'h00);
      if (ctrl[CTRL_DTYPE]) begin
        post_vec <= {i_has_parent ? i_parent16 : NO_PARENT, // [RULE_11]
                     i_role, i_event, // [RULE_12] [RULE_13]
                     PROFILE_ID, MAKER_ID, // [RULE_14]
                     i_dev_type, // [RULE_15]
                     i_rssi}; // [RULE_16]
      end else begin
        post_vec <= {i_has_parent ? i_parent16 : NO_PARENT, // [RULE_11]
                     i_role, i_event, PROFILE_ID, MAKER_ID, // [RULE_14]
                     i_rssi, 32'h0}; // [RULE_16]
      end
    end else if (load && state == S_PRE) begin
      pre_vec <= pre_vec << 8;
    end else if (load && state == S_POST) begin
      post_vec <= post_vec << 8;
    end
  end

  // Output byte is held until taken; nothing moves while the host stalls
  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      o_tx_valid <= 1'b0;
      o_tx_data  <= 8'h00;
      o_tx_last  <= 1'b0;
    end else if (load) begin
      o_tx_valid <= 1'b1; // [RULE_18]
      o_tx_data  <= cur_byte;
      o_tx_last  <= (state == S_CSUM);
    end else if (i_tx_ready) begin
      o_tx_valid <= 1'b0;
      o_tx_last  <= 1'b0;
    end
  end

  // Sum covers frame type through the byte before the checksum
  assign lk.sum_clr  = accept;
  assign lk.sum_en   = load && (state == S_PRE || state == S_STR
                               || state == S_POST); // [RULE_17]
  assign lk.sum_data = cur_byte;

  // String writes are refused while a frame is being sent
  assign lk.wr    = i_str_wr && (state == S_IDLE);
  assign lk.wdata = i_str_byte;
  assign lk.clr   = load && (state == S_CSUM);
  assign lk.raddr = idx;

  // Local identification triggers; join cases need the notify bit
  assign cmd_trig = apb_done && i_pwrite && (i_paddr == REG_CMD)
                    && (i_pwdata == CMD_COMMISSION);

  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      o_ident_send  <= 1'b0;
      o_ident_event <= 8'h00;
    end else begin
      o_ident_send <= i_button_press || cmd_trig
                   || ((i_joined || i_power_assoc) && ctrl[CTRL_JOIN]); // [RULE_02]
      if (i_button_press || cmd_trig) begin
        o_ident_event <= EVT_BUTTON; // [RULE_02]
      end else if (i_joined && ctrl[CTRL_JOIN]) begin
        o_ident_event <= EVT_JOIN;
      end else if (i_power_assoc && ctrl[CTRL_JOIN]) begin
        o_ident_event <= EVT_POWER;
      end
    end
  end

  // APB slave: one wait state, read data and error registered with pready
  assign apb_acc  = i_psel && i_penable;
  assign apb_done = apb_acc && o_pready;

  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready  <= apb_acc && !o_pready;
      o_pslverr <= apb_acc && !o_pready && (i_paddr != REG_CTRL)
                   && (i_paddr != REG_CMD) && (i_paddr != REG_STATUS);
      o_prdata  <= 32'h0;
      if (apb_acc && !o_pready && !i_pwrite) begin
        case (i_paddr)
          REG_CTRL:   o_prdata <= {29'h0, ctrl};
          REG_STATUS: o_prdata <= {frame_cnt, lk.count, 7'h0,
                                   (state != S_IDLE)};
          default:    o_prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl <= CTRL_RESET;
    end else if (apb_done && i_pwrite && i_paddr == REG_CTRL) begin
      ctrl <= i_pwdata[2:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      frame_cnt <= 16'h0;
    end else if (load && state == S_CSUM) begin
      frame_cnt <= frame_cnt + 16'h1;
    end
  end

  // Helper: counts checksummed bytes of the current frame
  logic [15:0] body_cnt;
  logic [15:0] len_q;
  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      body_cnt <= 16'h0;
      len_q    <= 16'h0;
    end else if (accept) begin
      body_cnt <= 16'h0;
    end else begin
      if (lk.sum_en) body_cnt <= body_cnt + 16'h1;
      if (load && state == S_HEAD && idx == 8'h00) len_q <= frame_len;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!rst_sync_n);

  a_frame_starts: assert property ( // [RULE_01]
    accept && (!o_tx_valid || i_tx_ready)
    |-> ##2 (o_tx_valid && o_tx_data == START_DELIM))
    else $error("Accepted request did not start a frame");
  a_ident_join: assert property ( // [RULE_02]
    i_joined && ctrl[CTRL_JOIN] && !i_button_press && !cmd_trig
    |=> o_ident_send && o_ident_event == EVT_JOIN)
    else $error("Join with notify gave no broadcast");
  a_start_delim: assert property ( // [RULE_03]
    load && state == S_HEAD && idx == 8'h00 |=> o_tx_data == START_DELIM)
    else $error("Frame did not open with start delimiter");
  a_length_count: assert property ( // [RULE_04]
    load && state == S_CSUM |-> body_cnt == len_q)
    else $error("Length field disagrees with body size");
  a_frame_type: assert property ( // [RULE_05]
    load && state == S_PRE && idx == 8'h00 |=> o_tx_data == FRAME_TYPE)
    else $error("Wrong frame type byte");
  a_options_clean: assert property ( // [RULE_07]
    load && state == S_PRE && idx == 8'h0b
    |=> (o_tx_data & ~OPT_KEEP) == 8'h00)
    else $error("Reserved option bit sent");
  a_string_null: assert property ( // [RULE_10]
    load && state == S_STR && last_in_state
    |-> idx >= 8'(MIN_STR - 1) ##1 o_tx_data == NULL_CHAR)
    else $error("Identifier string badly terminated");
  a_parent_none: assert property ( // [RULE_11]
    load && state == S_POST && idx <= 8'h01 && !has_parent_q
    |=> o_tx_data == (($past(idx) == 8'h00) ? NO_PARENT[15:8]
                                            : NO_PARENT[7:0]))
    else $error("Missing parent not sent as FFFE");
  a_checksum: assert property ( // [RULE_17]
    load && state == S_CSUM
    |=> 8'(o_tx_data + $past(lk.sum)) == CSUM_BASE && o_tx_last)
    else $error("Checksum byte wrong");
  a_hold_stall: assert property ( // [RULE_18]
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("Byte changed while stalled");
endmodule // node_ident_indicator_framer

// file: dv/host_sink.sv
// Host-side model that takes the framer's byte stream
module host_sink (
  input  wire logic       i_clk_sys,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_last,
  input  wire logic       i_slow,
  output logic            o_tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];
  int         last_at = -1;
  logic [2:0] tick = 3'h0;
  initial o_tx_ready = 1'b0;
  // A slow host refuses most cycles so the framer must hold each byte
  always @(posedge i_clk_sys) begin
    tick <= tick + 3'h1;
    o_tx_ready <= !i_slow || tick == 3'h2 || tick == 3'h5;
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) begin
      got.push_back(i_tx_data);
      if (i_tx_last === 1'b1) last_at = got.size() - 1;
    end
  end
endmodule // host_sink

// file: dv/node_ident_indicator_framer_tb_top.sv
// Self-checking bench for the identification indicator framer
module node_ident_indicator_framer_tb_top;
  import ni_framer_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] PROF = 16'h1357; // Arbitrary value
  localparam logic [15:0] MAKR = 16'h2468; // Arbitrary value
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, idv = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, dty = 32'h5a6b7c8d, prdata, rd;
  logic [63:0] s64 = 64'h0123456789abcdef, r64 = 64'hfedcba9876543210;
  logic [15:0] s16 = 16'h8a3c, r16 = 16'h5b21, par = 16'h4417;
  logic [7:0]  opt = '0, role = '0, evt = '0, rssi = 8'hc4, sb = '0;
  logic [7:0]  txd, ievt, lev, e[$], g[$];
  logic        hp = 0, swr = 0, btn = 0, joined = 0, pw = 0, slow = 0, er;
  logic        pready, pslverr, idready, txv, txl, txr, isend;
  int          mismatches = 0, n_compared = 0, cyc = 0, pulses = 0;

  node_ident_indicator_framer #(.PROFILE_ID(PROF), .MAKER_ID(MAKR)) uut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_id_valid(idv),
    .o_id_ready(idready), .i_src64(s64), .i_src16(s16), .i_options(opt),
    .i_rem16(r16), .i_rem64(r64), .i_parent16(par), .i_has_parent(hp),
    .i_role(role), .i_event(evt), .i_dev_type(dty), .i_rssi(rssi),
    .i_str_wr(swr), .i_str_byte(sb), .o_tx_valid(txv), .o_tx_data(txd),
    .o_tx_last(txl), .i_tx_ready(txr), .i_button_press(btn),
    .i_joined(joined), .i_power_assoc(pw), .o_ident_send(isend),
    .o_ident_event(ievt));
  host_sink sink (.i_clk_sys(clk), .i_tx_valid(txv), .i_tx_data(txd),
    .i_tx_last(txl), .i_slow(slow), .o_tx_ready(txr));

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (isend === 1'b1) begin
      pulses++;
      lev = ievt;
    end
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    // The wait ends when pready rises, or at the bench timeout if it never does
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, pen} <= 2'b00;
  endtask

  task automatic put(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) e.push_back(v[8*i +: 8]);
  endtask

  // Holding the request past acceptance proves a busy framer drops it
  task automatic frame(input int k, input string s, input logic [7:0] o,
                       input logic hpar, input logic [1:0] en,
                       input logic sl);
    int n, t;
    logic [7:0] sum;
    e = {};
    put(FRAME_TYPE, 1);
    put(s64, 8);
    put(s16, 2);
    put(o & OPT_KEEP, 1);
    put(r16, 2);
    put(r64, 8);
    for (n = 0; n < s.len(); n++) put(s[n], 1);
    if (s.len() == 0) put(PAD_CHAR, 1);
    put(NULL_CHAR, 1);
    t = e.size() + 3;
    put(hpar ? par : NO_PARENT, 2);
    put(k % 3, 1);
    put(k % 3 + 1, 1);
    put({PROF, MAKR}, 4);
    if (en[0]) put(dty, 4);
    if (en[1]) put(rssi, 1);
    sum = '0;
    foreach (e[i]) sum += e[i];
    n = e.size();
    e = {START_DELIM, 8'(n >> 8), 8'(n), e, CSUM_BASE - sum};
    sink.got = {};
    sink.last_at = -1;
    for (n = 0; n < s.len(); n++) begin
      @(posedge clk);
      {swr, sb} <= {1'b1, 8'(s[n])};
    end
    @(posedge clk);
    {swr, slow} <= {1'b0, sl};
    {idv, opt, hp, role, evt} <= {1'b1, o, hpar, 8'(k % 3), 8'(k % 3 + 1)};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (idready !== 1'b1 && n < 50);
    repeat (3) @(posedge clk);
    idv <= 1'b0;
    for (n = 0; n < 900 && sink.last_at < 0; n++) @(posedge clk);
    repeat (12) @(posedge clk);
    #1;
    g = sink.got;
    check(g.size(), e.size());
    check(sink.last_at, e.size() - 1);
    if (g.size() != e.size()) return;
    for (n = 0; n < 3; n++) check(g[n], e[n]);
    for (n = 3; n < 25; n++) check(g[n], e[n]);
    for (n = 14; n < 25; n++) check(g[n], e[n]);
    for (n = 25; n < t; n++) check(g[n], e[n]);
    for (n = t; n < t + 4; n++) check(g[n], e[n]);
    for (n = t + 4; n < t + 8; n++) check(g[n], e[n]);
    for (n = t + 8; n < g.size(); n++) check(g[n], e[n]);
  endtask

  task automatic trig(input int which, input logic fire, input logic [7:0] ex);
    pulses = 0;
    if (which == 3) apb(1'b1, REG_CMD, CMD_COMMISSION);
    else begin
      @(posedge clk);
      {btn, joined, pw} <= 3'(4 >> which);
      @(posedge clk);
      {btn, joined, pw} <= 3'h0;
    end
    repeat (4) @(posedge clk);
    #1;
    check(pulses, fire);
    if (fire) check(lev, ex);
  endtask

  task close_out;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, REG_CTRL, '0);
    check(rd, {29'h0, CTRL_RESET});
    apb(1'b0, 12'h00c, '0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    frame(0, "node", 8'h42, 1'b0, 2'b00, 1'b0);
    for (int k = 1; k < 4; k++) frame(k, k == 3 ? "" : "a", {2'(k), 6'h3f},
                                      1'b0, 2'b00, 1'b0);
    apb(1'b1, REG_CTRL, 32'h3);
    apb(1'b0, REG_CTRL, '0);
    check(rd, 32'h3);
    frame(4, "abcdefgh", 8'h86, 1'b1, 2'b11, 1'b1);
    apb(1'b0, REG_STATUS, '0);
    check(rd, 32'h00050000);
    trig(0, 1'b1, EVT_BUTTON);
    trig(3, 1'b1, EVT_BUTTON);
    trig(1, 1'b0, EVT_JOIN);
    apb(1'b1, REG_CTRL, 32'h4);
    trig(1, 1'b1, EVT_JOIN);
    trig(2, 1'b1, EVT_POWER);
    close_out();
  end
endmodule // node_ident_indicator_framer_tb_top
